// file: rtl/ursf_fifo.sv
// Four-deep receive character queue with its error tags stored beside each character.
// Assumes one write and one read per cycle at most; flush wins over both.
`timescale 1ns/1ps
module ursf_fifo #(
  parameter int unsigned DEPTH = ursf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic flush,
  // Write side
  input wire logic wr_en,
  input wire ursf_pkg::ursf_char_t wr_char,
  // Read side
  input wire logic rd_en,
  output ursf_pkg::ursf_char_t head_char,
  output logic empty,
  output logic full
);
  import ursf_pkg::*;
  localparam int unsigned PW = $clog2(DEPTH);
  ursf_char_t mem_ff [DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [PW:0] count_ff;
  logic do_wr;
  logic do_rd;

  assign do_wr = wr_en && !full;
  assign do_rd = rd_en && !empty;
  assign empty = (count_ff == '0);
  assign full = (count_ff == (PW+1)'(DEPTH));
  assign head_char = mem_ff[rptr_ff];

  always_ff @(posedge aclk) begin
    if (do_wr) begin
      mem_ff[wptr_ff] <= wr_char;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_wr) begin
        wptr_ff <= (wptr_ff == PW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      end
      if (do_rd) begin
        rptr_ff <= (rptr_ff == PW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      end
      count_ff <= count_ff + (PW+1)'(do_wr) - (PW+1)'(do_rd);
    end
  end
endmodule : ursf_fifo

// file: rtl/ursf_pkg.sv
// Package of the receive status block: register map, field positions, timing and carrier types.
// Assumes a 32-bit AXI4-Lite register bus and a 25 MHz clock.
package ursf_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned DATA_W = 9;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_BAUD_DIV = 8'h18;

  localparam int unsigned BIT_DATA_AVAIL = 0;
  localparam int unsigned BIT_OVERRUN = 1;
  localparam int unsigned BIT_FRAMING = 2;
  localparam int unsigned BIT_PARITY = 3;
  localparam int unsigned BIT_IDLE = 4;
  localparam int unsigned BIT_ADDR_EN = 5;

  localparam int unsigned CFG_NINE_BIT = 0;
  localparam int unsigned CFG_PAR_EN = 1;
  localparam int unsigned CFG_PAR_ODD = 2;
  localparam int unsigned CFG_RX_EN = 3;
  localparam logic [3:0] CFG_RESET = 4'h8;

  localparam int unsigned IRQ_RX_DATA = 0;
  localparam int unsigned IRQ_ERROR = 1;
  localparam int unsigned IRQ_ADDR = 2;
  localparam int unsigned IRQ_W = 3;

  localparam int unsigned DIV_DEFAULT = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);
  localparam logic [15:0] DIV_RESET = 16'(DIV_DEFAULT);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic addr_flag;
    logic parity_err;
    logic framing_err;
    logic [DATA_W-1:0] data;
  } ursf_char_t;

  typedef struct packed {
    logic nine_bit;
    logic par_en;
    logic par_odd;
    logic rx_en;
  } ursf_cfg_t;
endpackage : ursf_pkg

// file: rtl/ursf_rx_shift.sv
// Receive shift register: start detect, 16x sampling, data, parity and stop check.
// Assumes rx_sync already passed a two-flop synchroniser and tick is a one-cycle 16x enable.
`timescale 1ns/1ps
module ursf_rx_shift (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic tick,
  input wire logic abort,
  input wire ursf_pkg::ursf_cfg_t cfg,
  input wire logic rx_sync,
  // Result
  output logic busy,
  output logic done,
  output ursf_pkg::ursf_char_t char_out
);
  import ursf_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PAR = 3'b011,
    ST_STOP = 3'b100
  } ursf_rx_st_t;
  ursf_rx_st_t st_ff;
  logic [3:0] os_ff;
  logic [3:0] bit_ff;
  logic [DATA_W-1:0] sh_ff;
  logic par_ff;
  logic mid;
  logic [3:0] nbits;

  assign mid = tick && (os_ff == 4'hF);
  assign nbits = cfg.nine_bit ? 4'h9 : 4'h8;
  assign busy = (st_ff != ST_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn || abort || !cfg.rx_en) begin
      st_ff <= ST_IDLE;
      os_ff <= 4'h0;
      bit_ff <= 4'h0;
      sh_ff <= '0;
      par_ff <= 1'b0;
      done <= 1'b0;
      char_out <= '0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        os_ff <= os_ff + 4'h1;
      end
      unique case (st_ff)
        ST_IDLE: begin
          if (!rx_sync) begin
            st_ff <= ST_START;
            os_ff <= 4'h8;
          end
        end
        ST_START: begin
          if (mid) begin
            st_ff <= rx_sync ? ST_IDLE : ST_DATA;
            bit_ff <= 4'h0;
            sh_ff <= '0;
            par_ff <= 1'b0;
          end
        end
        ST_DATA: begin
          if (mid) begin
            sh_ff <= cfg.nine_bit ? {rx_sync, sh_ff[DATA_W-1:1]} : {1'b0, rx_sync, sh_ff[DATA_W-2:1]};
            par_ff <= par_ff ^ rx_sync;
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == nbits - 4'h1) begin
              st_ff <= (cfg.par_en && !cfg.nine_bit) ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (mid) begin
            par_ff <= par_ff ^ rx_sync ^ cfg.par_odd;
            st_ff <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (mid) begin
            st_ff <= ST_IDLE;
            done <= 1'b1;
            char_out.data <= sh_ff;
            char_out.framing_err <= !rx_sync;
            char_out.parity_err <= cfg.par_en && !cfg.nine_bit && par_ff;
            char_out.addr_flag <= cfg.nine_bit && sh_ff[DATA_W-1];
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : ursf_rx_shift

// file: rtl/ursf_top.sv
// Receive status and address-detect block of an asynchronous serial receiver behind AXI4-Lite.
// Assumes rx_pin is asynchronous to aclk and software services the queue over the bus.
// Assumes one write and one read at most in flight, and a master that waits for every ready.
//
// Behaviour
// RULE_01: Address detect only in nine-bit mode.
// RULE_02: Idle flag high unless character in progress.
// RULE_03: Parity flag describes queue head character.
// RULE_04: Framing flag describes queue head character.
// RULE_05: Overrun sticky, cleared only by software.
// RULE_06: Clearing overrun flushes queue and shifter.
// RULE_07: Data available while queue holds characters.
// RULE_08: Receive queue is four characters deep.
// RULE_09: One error interrupt for all receiver errors.
// RULE_10: On overrun drop character, stop loading.
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ursf_top #(
  parameter int unsigned DEPTH = ursf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial line
  input wire logic rx_pin,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupts
  output logic irq,
  output logic error_irq
);
  import ursf_pkg::*;

  logic rx_meta_ff;
  logic rx_sync_ff;
  logic [15:0] div_cnt_ff;
  logic [15:0] baud_div_ff;
  logic tick_ff;
  ursf_cfg_t cfg_ff;
  logic address_detect_enable_ff;
  logic overrun_error_flag_ff;
  logic [IRQ_W-1:0] irq_status_ff;
  logic [IRQ_W-1:0] irq_enable_ff;
  logic [7:0] awaddr_ff;
  logic aw_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic flush_ff;

  logic rx_busy;
  logic rx_done;
  ursf_char_t rx_char;
  ursf_char_t head_char;
  logic fifo_empty;
  logic fifo_full;
  logic accept_char;
  logic overrun_event;
  logic wr_fire;
  logic rd_fire;
  logic data_pop;
  logic clear_overrun;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;
  logic [31:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic [31:0] status_word;

  // The first synchroniser flop feeds only the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
    end else begin
      rx_meta_ff <= rx_pin;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // Sixteen-times sampling enable from the programmable divider.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_cnt_ff >= baud_div_ff) begin
      div_cnt_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  ursf_rx_shift u_shift (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_ff),
    .abort(flush_ff), // RULE_06
    .cfg(cfg_ff),
    .rx_sync(rx_sync_ff),
    .busy(rx_busy),
    .done(rx_done),
    .char_out(rx_char)
  );

  ursf_fifo #(
    .DEPTH(DEPTH) // RULE_08
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(flush_ff), // RULE_06
    .wr_en(accept_char),
    .wr_char(rx_char),
    .rd_en(data_pop),
    .head_char(head_char),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // In address-detect mode only address characters enter the queue.
  logic addr_gate;
  assign addr_gate = !(address_detect_enable_ff && cfg_ff.nine_bit) ||
                     rx_char.addr_flag; // RULE_01
  // Loading stops while overrun stands, so the queue keeps the older characters.
  // A character finishing during the flush goes with the queue and sets no overrun.
  assign accept_char = rx_done && addr_gate && !fifo_full &&
                       !overrun_error_flag_ff && !flush_ff; // RULE_10
  assign overrun_event = rx_done && addr_gate && fifo_full &&
                         !overrun_error_flag_ff && !flush_ff; // RULE_10

  // Bus handshakes: address and data are taken independently and held until both are present.
  assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= ADDR_BAUD_DIV);
  assign wr_ok = (awaddr_ff[1:0] == 2'h0) && (awaddr_ff <= ADDR_BAUD_DIV);
  assign data_pop = rd_fire && (s_axi_araddr == ADDR_DATA);
  assign clear_overrun = wr_fire && (awaddr_ff == ADDR_STATUS) && wstrb_ff[0] &&
                         !wdata_ff[BIT_OVERRUN] && overrun_error_flag_ff; // RULE_06
  assign irq_clear = (wr_fire && (awaddr_ff == ADDR_IRQ_CLEAR) && wstrb_ff[0]) ?
                     wdata_ff[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_ff && !s_axi_bvalid;
    end
  end

  // The answer waits for both halves of the write, whichever came first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writable configuration, address-detect enable, interrupt enable and divider.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // The reset word is in register order, the reverse of the field order.
      cfg_ff <= ursf_cfg_t'({CFG_RESET[CFG_NINE_BIT], CFG_RESET[CFG_PAR_EN], CFG_RESET[CFG_PAR_ODD],
                             CFG_RESET[CFG_RX_EN]});
      address_detect_enable_ff <= 1'b0;
      irq_enable_ff <= '0;
      baud_div_ff <= DIV_RESET;
    end else if (wr_fire && wstrb_ff[0]) begin
      if (awaddr_ff == ADDR_STATUS) begin
        address_detect_enable_ff <= wdata_ff[BIT_ADDR_EN];
      end
      if (awaddr_ff == ADDR_CONFIG) begin
        cfg_ff <= ursf_cfg_t'({wdata_ff[CFG_NINE_BIT], wdata_ff[CFG_PAR_EN], wdata_ff[CFG_PAR_ODD],
                               wdata_ff[CFG_RX_EN]});
      end
      if (awaddr_ff == ADDR_IRQ_ENABLE) begin
        irq_enable_ff <= wdata_ff[IRQ_W-1:0];
      end
      if (awaddr_ff == ADDR_BAUD_DIV) begin
        baud_div_ff <= wdata_ff[15:0];
      end
    end
  end

  // Overrun is set by hardware only; a fresh overrun beats a clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_error_flag_ff <= 1'b0;
    end else if (overrun_event) begin
      overrun_error_flag_ff <= 1'b1; // RULE_05
    end else if (clear_overrun) begin
      overrun_error_flag_ff <= 1'b0; // RULE_05
    end
  end

  // Flush is a registered pulse one cycle after the clearing write.
  // It also aborts a frame in progress, so the shifter restarts empty.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= clear_overrun; // RULE_06
    end
  end

  // Interrupt events; the error event covers parity, framing and overrun alike.
  assign irq_events[IRQ_RX_DATA] = accept_char;
  assign irq_events[IRQ_ERROR] = overrun_event ||
                                 (accept_char && (rx_char.parity_err || rx_char.framing_err)); // RULE_09
  assign irq_events[IRQ_ADDR] = accept_char && rx_char.addr_flag;

  // Set beats clear, so an event in the clearing cycle is not lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
    end
  end

  // Both lines come from flops, so a decode never glitches them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      irq <= |(irq_status_ff & irq_enable_ff);
      error_irq <= irq_status_ff[IRQ_ERROR] && irq_enable_ff[IRQ_ERROR]; // RULE_09
    end
  end

  // Error flags read zero on an empty queue, whose head slot is stale.
  always_comb begin
    status_word = 32'h00000000;
    status_word[BIT_ADDR_EN] = address_detect_enable_ff;
    status_word[BIT_IDLE] = !rx_busy; // RULE_02
    status_word[BIT_PARITY] = !fifo_empty && head_char.parity_err; // RULE_03
    status_word[BIT_FRAMING] = !fifo_empty && head_char.framing_err; // RULE_04
    status_word[BIT_OVERRUN] = overrun_error_flag_ff;
    status_word[BIT_DATA_AVAIL] = !fifo_empty; // RULE_07
  end

  // Register map, byte offsets.
  // 0x00: b0 data available, b1 overrun, b2 framing,
  //   b3 parity, b4 idle, b5 address detect enable.
  //   Writing 0 to a set b1 clears it and flushes.
  // 0x04: head character; the read pops it.
  // 0x08: b0 nine-bit, b1 parity, b2 odd, b3 enable.
  // 0x0C: events b0 char, b1 error, b2 address.
  // 0x10: event clear, write ones; reads zero.
  // 0x14: event enable, same layout.
  // 0x18: a tick every divider plus one clocks.
  // Other offsets answer with a slave error.
  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      ADDR_STATUS: rd_word = status_word;
      ADDR_DATA: rd_word = fifo_empty ? 32'h00000000 : {23'h000000, head_char.data};
      ADDR_CONFIG: rd_word = {28'h0000000, cfg_ff.rx_en, cfg_ff.par_odd, cfg_ff.par_en, cfg_ff.nine_bit};
      ADDR_IRQ_STATUS: rd_word = {29'h00000000, irq_status_ff};
      ADDR_IRQ_ENABLE: rd_word = {29'h00000000, irq_enable_ff};
      ADDR_BAUD_DIV: rd_word = {16'h0000, baud_div_ff};
      default: rd_word = 32'h00000000;
    endcase
  end

  // The read address opens on alternate idle cycles; a master must wait for arready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= !s_axi_arready;
    end
  end
endmodule : ursf_top

// file: verif/ursf_line_model.sv
// Remote asynchronous transmitter driving the receive line, one frame per send call.
// Assumes the caller enters send just after a rising clock edge; the line idles high.
`timescale 1ns/1ps
module ursf_line_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic aclk,
  // Serial line
  output logic line
);
  initial line = 1'b1;

  // Bits go out LSB first after the start bit; the top bit given is the stop bit.
  task automatic send(input logic [10:0] bits, input int n);
    line <= 1'b0;
    repeat (BIT_CLKS) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (BIT_CLKS) @(posedge aclk);
    end
    line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge aclk);
  endtask : send
endmodule : ursf_line_model

// file: verif/ursf_properties.sv
// Concurrent checks of the receive status block, seen only through its top-level ports.
// Assumes the bind at the foot of this file attaches it to every ursf_top instance.
`timescale 1ns/1ps
module ursf_props #(
  parameter int unsigned DEPTH = ursf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial line
  input wire logic rx_pin,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupts
  input wire logic irq,
  input wire logic error_irq
);
  import ursf_pkg::*;
  // A high run this long outlasts any frame at the reset divider or faster, so the receiver must be idle.
  localparam int IDLE_GAP = 2300;
  logic [11:0] hi_cnt_ff;
  logic [7:0] rd_addr_ff;
  logic rd_quiet_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_pin) begin
      hi_cnt_ff <= 12'h000;
    end else if (hi_cnt_ff != 12'hFFF) begin
      hi_cnt_ff <= hi_cnt_ff + 12'h001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr_ff <= 8'h00;
      rd_quiet_ff <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_ff <= s_axi_araddr;
      rd_quiet_ff <= hi_cnt_ff >= 12'(IDLE_GAP);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_answer_late: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer did not follow the address");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed before taken");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped before taken");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while a response is pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while a response is pending");
  a_head_flags_empty: assert property (
    s_axi_rvalid && rd_addr_ff == ADDR_STATUS && !s_axi_rdata[BIT_DATA_AVAIL] |-> s_axi_rdata[3:2] == 2'h0)
    else $error("error flags shown with an empty queue");
  a_idle_after_quiet: assert property (
    s_axi_rvalid && rd_addr_ff == ADDR_STATUS && rd_quiet_ff |-> s_axi_rdata[BIT_IDLE])
    else $error("idle flag low on a long quiet line");
  a_bad_addr_error: assert property (s_axi_rvalid && (rd_addr_ff > ADDR_BAUD_DIV || rd_addr_ff[1:0] != 2'h0)
    |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_clear_reads_zero: assert property (s_axi_rvalid && rd_addr_ff == ADDR_IRQ_CLEAR
    |-> s_axi_rresp == RESP_OKAY && s_axi_rdata == 32'h0000_0000)
    else $error("clear register read not zero");
  a_error_irq_in_irq: assert property (error_irq |-> irq)
    else $error("error interrupt without summary interrupt");
endmodule : ursf_props

bind ursf_top ursf_props #(.DEPTH(DEPTH)) props (.aclk, .aresetn, .rx_pin, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq, .error_irq);

// file: verif/ursf_top_bench.sv
// Self-checking bench of the receive status block: AXI4-Lite register tasks and serial frames.
// Assumes the divider is set to zero so a bit lasts 16 clocks.
`timescale 1ns/1ps
module ursf_top_bench;
  import ursf_pkg::*;
  logic aclk, aresetn, rx_pin, irq, error_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int mismatches, comparisons;

  ursf_top #(.DEPTH(FIFO_DEPTH)) dut (.aclk, .aresetn, .rx_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .error_irq);
  ursf_line_model #(.BIT_CLKS(16)) line (.aclk, .line(rx_pin));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 100) begin
      chk("bus handshake", 32'h0, 32'h1);
      conclude();
    end
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    logic aw_done = 1'b0;
    logic w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      step(n);
      if (s_axi_awready === 1'b1 && !aw_done) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (s_axi_wready === 1'b1 && !w_done) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do step(n); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rd_resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do step(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do step(n); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string name);
    rd(a);
    chk(name, rd_data, exp);
  endtask : rc

  // The bit just above the data field carries the stop level.
  task automatic tx(input logic [8:0] d, input int nb, input logic stop);
    logic [10:0] bits;
    bits = 11'(d);
    bits[nb] = stop;
    @(posedge aclk);
    line.send(bits, nb + 1);
  endtask : tx

  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, mismatches, comparisons} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2400) @(posedge aclk);
    rc(ADDR_STATUS, 32'h10, "status after reset");
    rc(ADDR_CONFIG, 32'h8, "config reset");
    rc(ADDR_BAUD_DIV, 32'(DIV_RESET), "divider reset");
    rd(8'h1C);
    chk("unmapped read resp", 32'(rd_resp), 32'(RESP_SLVERR));
    wr(8'h1C, 32'h1);
    chk("unmapped write resp", 32'(rd_resp), 32'(RESP_SLVERR));
    rc(ADDR_IRQ_CLEAR, 32'h0, "clear register read");
    wr(ADDR_BAUD_DIV, 32'h0);
    fork
      tx(9'h0A5, 8, 1'b1);
      begin
        repeat (60) @(posedge aclk);
        rc(ADDR_STATUS, 32'h0, "status mid frame");
      end
    join
    chk("irq masked", 32'(irq), 32'h0);
    rc(ADDR_STATUS, 32'h11, "status one char");
    rc(ADDR_IRQ_STATUS, 32'h1, "char event");
    wr(ADDR_IRQ_ENABLE, 32'h7);
    repeat (2) @(posedge aclk);
    chk("irq enabled", 32'(irq), 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'(irq), 32'h0);
    rc(ADDR_DATA, 32'h0A5, "first char");
    rc(ADDR_STATUS, 32'h10, "status drained");
    tx(9'h03C, 8, 1'b0);
    rc(ADDR_STATUS, 32'h15, "framing head");
    chk("error irq framing", 32'(error_irq), 32'h1);
    rc(ADDR_DATA, 32'h03C, "framed char");
    rc(ADDR_STATUS, 32'h10, "framing gone");
    wr(ADDR_IRQ_CLEAR, 32'h7);
    wr(ADDR_CONFIG, 32'hA);
    tx(9'h001, 9, 1'b1);
    tx(9'h003, 9, 1'b1);
    rc(ADDR_STATUS, 32'h19, "parity head");
    chk("error irq parity", 32'(error_irq), 32'h1);
    rc(ADDR_DATA, 32'h001, "bad parity char");
    rc(ADDR_STATUS, 32'h11, "good parity head");
    rc(ADDR_DATA, 32'h003, "good parity char");
    wr(ADDR_IRQ_CLEAR, 32'h7);
    wr(ADDR_CONFIG, 32'h8);
    for (int i = 0; i < 4; i++) tx(9'(8'h10 + i), 8, 1'b1);
    rc(ADDR_STATUS, 32'h11, "queue full no overrun");
    tx(9'h014, 8, 1'b1);
    tx(9'h015, 8, 1'b1);
    rc(ADDR_STATUS, 32'h13, "overrun set");
    chk("error irq overrun", 32'(error_irq), 32'h1);
    wr(ADDR_STATUS, 32'h2);
    rc(ADDR_STATUS, 32'h13, "overrun write one");
    for (int i = 0; i < 4; i++) rc(ADDR_DATA, 32'h10 + i, "kept chars");
    rc(ADDR_STATUS, 32'h12, "overrun sticky");
    wr(ADDR_STATUS, 32'h0);
    rc(ADDR_STATUS, 32'h10, "overrun cleared");
    for (int i = 0; i < 5; i++) tx(9'(8'h20 + i), 8, 1'b1);
    wr(ADDR_STATUS, 32'h0);
    rc(ADDR_STATUS, 32'h10, "flushed");
    tx(9'h02A, 8, 1'b1);
    rc(ADDR_DATA, 32'h02A, "after flush");
    wr(ADDR_IRQ_CLEAR, 32'h7);
    wr(ADDR_CONFIG, 32'h9);
    wr(ADDR_STATUS, 32'h20);
    tx(9'h055, 9, 1'b1);
    tx(9'h1AA, 9, 1'b1);
    rc(ADDR_STATUS, 32'h31, "address only");
    rc(ADDR_IRQ_STATUS, 32'h5, "address event");
    rc(ADDR_DATA, 32'h1AA, "address char");
    wr(ADDR_CONFIG, 32'h8);
    tx(9'h055, 8, 1'b1);
    rc(ADDR_DATA, 32'h055, "eight bit ignores detect");
    conclude();
  end
endmodule : ursf_top_bench
